// ### verilog/uart_regs_defs.svh
// register offsets, field positions and reset values of one uart channel
`ifndef UART_REGS_DEFS_SVH
`define UART_REGS_DEFS_SVH
`define ADDR_DATA 3'h0
`define ADDR_IRQ_ENABLE 3'h1
`define ADDR_IRQ_FIFO 3'h2
`define ADDR_LINE_CONTROL 3'h3
`define ADDR_MODEM_CONTROL 3'h4
`define ADDR_LINE_STATUS 3'h5
`define ADDR_MODEM_STATUS 3'h6
`define ADDR_SCRATCH_PAD 3'h7
`define LINE_CTRL_DIV_ACCESS 7
`define LINE_CTRL_EXT_KEY 8'hBF
`define FIFO_CTRL_ENABLE 0
`define FIFO_CTRL_RX_RESET 1
`define FIFO_CTRL_TX_RESET 2
`define FIFO_CTRL_KEEP_MASK 8'hC9
`define IRQ_ENABLE_MASK 8'h0F
`define MODEM_CTRL_MASK 8'h1F
`define MODEM_CTRL_DTR 0
`define MODEM_CTRL_RTS 1
`define MODEM_CTRL_SPARE 2
`define MODEM_CTRL_IRQ_OUT 3
`define MODEM_CTRL_LOOPBACK 4
`define RESET_LINE_CONTROL 8'h00
`define RESET_IRQ_ENABLE 8'h00
`define RESET_FIFO_CONTROL 8'h00
`define RESET_MODEM_CONTROL 8'h00
`define RESET_SCRATCH_PAD 8'hFF
`define RESET_DIVISOR 8'h00
`endif

// ### verilog/uart_regs_pkg.sv
// types shared by the uart channel register decode
package uart_regs_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] reg_addr_t;
    typedef logic [1:0] chan_t;
endpackage

// ### verilog/uart_channel_register_decode.sv
// register decode for the four channels of a quad uart
`timescale 1ns/1ns
`default_nettype none
`include "uart_regs_defs.svh"

module uart_channel_register_decode (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic [1:0] i_chan_sel,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic [31:0] i_rx_data,
    input wire logic [31:0] i_line_status,
    input wire logic [15:0] i_irq_code,
    input wire logic [3:0] i_cts_n,
    input wire logic [3:0] i_dsr_n,
    input wire logic [3:0] i_ri_n,
    input wire logic [3:0] i_cd_n,
    input wire logic [3:0] i_rx_pin,
    input wire logic [3:0] i_tx_shift_out,
    output logic [3:0] o_rx_shift_in,
    output logic [3:0] o_tx_pin,
    output logic [3:0] o_rts_n,
    output logic [3:0] o_dtr_n,
    output logic [3:0] o_irq_output_enable,
    output logic [3:0] o_spare_output_bit,
    output logic [3:0] o_loopback,
    output logic [31:0] o_line_control,
    output logic [31:0] o_irq_enable,
    output logic [31:0] o_fifo_control,
    output logic [63:0] o_divisor,
    output logic [7:0] o_tx_data,
    output logic [3:0] o_tx_load,
    output logic [3:0] o_rx_read,
    output logic [3:0] o_irq_status_read,
    output logic [3:0] o_line_status_read,
    output logic [3:0] o_modem_status_read,
    output logic [3:0] o_rx_fifo_reset,
    output logic [3:0] o_tx_fifo_reset
);

    uart_regs_pkg::byte_t line_control [4];
    uart_regs_pkg::byte_t irq_enable [4];
    uart_regs_pkg::byte_t fifo_control [4];
    uart_regs_pkg::byte_t modem_control [4];
    uart_regs_pkg::byte_t scratch_pad [4];
    uart_regs_pkg::byte_t divisor_low [4];
    uart_regs_pkg::byte_t divisor_high [4];
    uart_regs_pkg::byte_t read_value [4];
    logic [3:0] modem_delta [4];
    logic [3:0] modem_prev [4];
    logic [3:0] modem_live [4];

    // pins cross in through two flip-flops; stage one feeds only stage two
    logic [19:0] pin_meta;
    logic [19:0] pin_sync;
    wire logic [19:0] pin_raw = {i_rx_pin, i_cd_n, i_ri_n, i_dsr_n, i_cts_n};

    wire logic [3:0] wr_tx;
    wire logic [3:0] rd_rx;
    wire logic [3:0] rd_irq_status;
    wire logic [3:0] rd_line_status;
    wire logic [3:0] rd_modem_status;
    wire logic [3:0] fifo_rx_reset;
    wire logic [3:0] fifo_tx_reset;
    wire logic [3:0] loop_on;

    wire logic bus_rd = i_clk_en & i_rd & ~i_wr;
    wire logic bus_wr = i_clk_en & i_wr & ~i_rd;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_meta <= 20'hFFFFF;
            pin_sync <= 20'hFFFFF;
        end else if (i_clk_en) begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            wire logic sel = (i_chan_sel == 2'(g));
            // the extended key value keeps the divisor hidden even with bit 7 set
            wire logic div_on = line_control[g][`LINE_CTRL_DIV_ACCESS] &&
                                (line_control[g] != `LINE_CTRL_EXT_KEY);
            wire logic wr_hit = bus_wr & sel;
            wire logic rd_hit = bus_rd & sel;
            wire logic wr_div_low = wr_hit & (i_addr == `ADDR_DATA) & div_on;
            wire logic wr_div_high = wr_hit & (i_addr == `ADDR_IRQ_ENABLE) & div_on;
            wire logic wr_irq_enable = wr_hit & (i_addr == `ADDR_IRQ_ENABLE) & ~div_on;
            wire logic wr_fifo = wr_hit & (i_addr == `ADDR_IRQ_FIFO);
            wire logic fifo_ok = wr_fifo & i_wdata[`FIFO_CTRL_ENABLE];
            wire logic wr_line = wr_hit & (i_addr == `ADDR_LINE_CONTROL);
            wire logic wr_modem = wr_hit & (i_addr == `ADDR_MODEM_CONTROL);
            wire logic wr_scratch = wr_hit & (i_addr == `ADDR_SCRATCH_PAD);
            wire logic [3:0] pins_in = {pin_sync[12 + g], pin_sync[8 + g], pin_sync[4 + g], pin_sync[g]};

            assign wr_tx[g] = wr_hit & (i_addr == `ADDR_DATA) & ~div_on;
            assign rd_rx[g] = rd_hit & (i_addr == `ADDR_DATA) & ~div_on;
            assign rd_irq_status[g] = rd_hit & (i_addr == `ADDR_IRQ_FIFO);
            assign rd_line_status[g] = rd_hit & (i_addr == `ADDR_LINE_STATUS);
            assign rd_modem_status[g] = rd_hit & (i_addr == `ADDR_MODEM_STATUS);
            assign fifo_rx_reset[g] = fifo_ok & i_wdata[`FIFO_CTRL_RX_RESET];
            assign fifo_tx_reset[g] = fifo_ok & i_wdata[`FIFO_CTRL_TX_RESET];
            assign loop_on[g] = modem_control[g][`MODEM_CTRL_LOOPBACK];

            // in loopback the modem inputs follow the channel's own control outputs
            assign modem_live[g] = loop_on[g] ?
                {modem_control[g][`MODEM_CTRL_IRQ_OUT], modem_control[g][`MODEM_CTRL_SPARE],
                 modem_control[g][`MODEM_CTRL_DTR], modem_control[g][`MODEM_CTRL_RTS]} : ~pins_in;

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    line_control[g] <= `RESET_LINE_CONTROL;
                end else if (wr_line) begin
                    line_control[g] <= i_wdata;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    irq_enable[g] <= `RESET_IRQ_ENABLE;
                end else if (wr_irq_enable) begin
                    irq_enable[g] <= i_wdata & `IRQ_ENABLE_MASK;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    divisor_low[g] <= `RESET_DIVISOR;
                end else if (wr_div_low) begin
                    divisor_low[g] <= i_wdata;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    divisor_high[g] <= `RESET_DIVISOR;
                end else if (wr_div_high) begin
                    divisor_high[g] <= i_wdata;
                end
            end

            // reset bits are pulses, so they are never kept in the register
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    fifo_control[g] <= `RESET_FIFO_CONTROL;
                end else if (fifo_ok) begin
                    fifo_control[g] <= i_wdata & `FIFO_CTRL_KEEP_MASK;
                end else if (wr_fifo) begin
                    fifo_control[g][`FIFO_CTRL_ENABLE] <= 1'b0;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    modem_control[g] <= `RESET_MODEM_CONTROL;
                end else if (wr_modem) begin
                    modem_control[g] <= i_wdata & `MODEM_CTRL_MASK;
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    scratch_pad[g] <= `RESET_SCRATCH_PAD;
                end else if (wr_scratch) begin
                    scratch_pad[g] <= i_wdata;
                end
            end

            // a change seen in the read cycle survives the clear
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    modem_prev[g] <= 4'h0;
                    modem_delta[g] <= 4'h0;
                end else if (i_clk_en) begin
                    modem_prev[g] <= modem_live[g];
                    modem_delta[g] <= (rd_modem_status[g] ? 4'h0 : modem_delta[g]) |
                                      (modem_live[g] ^ modem_prev[g]);
                end
            end

            always_comb begin
                case (i_addr)
                    `ADDR_DATA: read_value[g] = div_on ? divisor_low[g] : i_rx_data[8 * g +: 8];
                    `ADDR_IRQ_ENABLE: read_value[g] = div_on ? divisor_high[g] : irq_enable[g];
                    `ADDR_IRQ_FIFO: read_value[g] = {{2{fifo_control[g][`FIFO_CTRL_ENABLE]}}, 2'h0,
                                                     i_irq_code[4 * g +: 4]};
                    `ADDR_LINE_CONTROL: read_value[g] = line_control[g];
                    `ADDR_MODEM_CONTROL: read_value[g] = modem_control[g];
                    `ADDR_LINE_STATUS: read_value[g] = i_line_status[8 * g +: 8];
                    `ADDR_MODEM_STATUS: read_value[g] = {modem_live[g], modem_delta[g]};
                    `ADDR_SCRATCH_PAD: read_value[g] = scratch_pad[g];
                    default: read_value[g] = 8'h00;
                endcase
            end

            assign o_line_control[8 * g +: 8] = line_control[g];
            assign o_irq_enable[8 * g +: 8] = irq_enable[g];
            assign o_fifo_control[8 * g +: 8] = fifo_control[g];
            assign o_divisor[16 * g +: 16] = {divisor_high[g], divisor_low[g]};
            assign o_loopback[g] = loop_on[g];
        end
    endgenerate

    // read data holds until the next read so the host may sample late
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (bus_rd) begin
            o_rdata <= read_value[i_chan_sel];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_data <= 8'h00;
        end else if (|wr_tx) begin
            o_tx_data <= i_wdata;
        end
    end

    // side-effect pulses toward the channel core, one clock each; frozen while the enable is low
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rx_read <= 4'h0;
            o_irq_status_read <= 4'h0;
            o_line_status_read <= 4'h0;
            o_modem_status_read <= 4'h0;
        end else if (i_clk_en) begin
            o_rx_read <= rd_rx;
            o_irq_status_read <= rd_irq_status;
            o_line_status_read <= rd_line_status;
            o_modem_status_read <= rd_modem_status;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_load <= 4'h0;
            o_rx_fifo_reset <= 4'h0;
            o_tx_fifo_reset <= 4'h0;
        end else if (i_clk_en) begin
            o_tx_load <= wr_tx;
            o_rx_fifo_reset <= fifo_rx_reset;
            o_tx_fifo_reset <= fifo_tx_reset;
        end
    end

    logic [3:0] ctl_rts;
    logic [3:0] ctl_dtr;
    logic [3:0] ctl_spare;
    logic [3:0] ctl_irq_out;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ctl_rts[i] = modem_control[i][`MODEM_CTRL_RTS];
            ctl_dtr[i] = modem_control[i][`MODEM_CTRL_DTR];
            ctl_spare[i] = modem_control[i][`MODEM_CTRL_SPARE];
            ctl_irq_out[i] = modem_control[i][`MODEM_CTRL_IRQ_OUT];
        end
    end

    // rts, dtr and spare pins are active low, the irq output enable is active high; loopback parks them deasserted
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rts_n <= 4'hF;
            o_dtr_n <= 4'hF;
            o_spare_output_bit <= 4'hF;
            o_irq_output_enable <= 4'h0;
        end else if (i_clk_en) begin
            o_rts_n <= ~(ctl_rts & ~loop_on);
            o_dtr_n <= ~(ctl_dtr & ~loop_on);
            o_spare_output_bit <= ~(ctl_spare & ~loop_on);
            o_irq_output_enable <= ctl_irq_out & ~loop_on;
        end
    end

    // the line stays at mark in loopback so the far end sees an idle channel
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tx_pin <= 4'hF;
            o_rx_shift_in <= 4'hF;
        end else if (i_clk_en) begin
            o_tx_pin <= i_tx_shift_out | loop_on;
            o_rx_shift_in <= (loop_on & i_tx_shift_out) | (~loop_on & pin_sync[19:16]);
        end
    end

endmodule
`default_nettype wire

// ### testbench/uart_decode_chk.sv
// assertions on the ports of the uart register decode
`timescale 1ns/1ns
`default_nettype none
module uart_decode_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic [1:0] i_chan_sel,
    input wire logic [2:0] i_addr,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic [31:0] i_rx_data,
    input wire logic [31:0] i_line_status,
    input wire logic [15:0] i_irq_code,
    input wire logic [3:0] i_tx_shift_out,
    input wire logic [3:0] o_rx_shift_in,
    input wire logic [3:0] o_tx_pin,
    input wire logic [3:0] o_loopback,
    input wire logic [31:0] o_line_control,
    input wire logic [31:0] o_irq_enable,
    input wire logic [31:0] o_fifo_control,
    input wire logic [7:0] o_tx_data,
    input wire logic [3:0] o_tx_load,
    input wire logic [3:0] o_rx_read,
    input wire logic [3:0] o_irq_status_read,
    input wire logic [3:0] o_line_status_read,
    input wire logic [3:0] o_modem_status_read,
    input wire logic [3:0] o_rx_fifo_reset,
    input wire logic [3:0] o_tx_fifo_reset
);
    logic [1:0] ch_q;
    wire logic [7:0] line_ctl = o_line_control[{i_chan_sel, 3'h0} +: 8];
    wire logic [7:0] rxb = i_rx_data[{i_chan_sel, 3'h0} +: 8];
    wire logic [7:0] lsb = i_line_status[{i_chan_sel, 3'h0} +: 8];
    wire logic [3:0] code = i_irq_code[{i_chan_sel, 2'h0} +: 4];
    wire logic fen = o_fifo_control[{i_chan_sel, 3'h0}];
    wire logic rd = i_clk_en & i_rd & ~i_wr;
    wire logic wr = i_clk_en & i_wr & ~i_rd;
    // 0xBF hides the divisor even with bit 7 set
    wire logic dmode = ~line_ctl[7] | (line_ctl == 8'hBF);
    always_ff @(posedge i_ref_clk) begin
        ch_q <= i_chan_sel;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    a_tx_load_pulse: assert property (wr && i_addr == 3'h0 && dmode |=>
        o_tx_load == (4'h1 << ch_q) && o_tx_data == $past(i_wdata)) else $error("transmit load wrong");
    a_read_no_write: assert property (rd |=> o_tx_load == 4'h0 && o_rx_fifo_reset == 4'h0)
        else $error("read disturbed a write register");
    a_rx_read_data: assert property (rd && i_addr == 3'h0 && dmode |=>
        o_rx_read == (4'h1 << ch_q) && o_rdata == $past(rxb)) else $error("receive read wrong");
    a_line_status_read: assert property (rd && i_addr == 3'h5 |=>
        o_line_status_read == (4'h1 << ch_q) && o_rdata == $past(lsb)) else $error("line status read wrong");
    a_modem_status_read: assert property (rd && i_addr == 3'h6 |=>
        o_modem_status_read == (4'h1 << ch_q)) else $error("modem status read pulse wrong");
    a_irq_status_read: assert property (rd && i_addr == 3'h2 |=> o_irq_status_read == (4'h1 << ch_q) &&
        o_rdata == {{2{$past(fen)}}, 2'h0, $past(code)}) else $error("irq status read wrong");
    a_irq_enable_mask: assert property (wr && i_addr == 3'h1 && dmode |=>
        o_irq_enable[{ch_q, 3'h0} +: 8] == ($past(i_wdata) & 8'h0F)) else $error("irq enable wrong");
    a_fifo_guard: assert property (wr && i_addr == 3'h2 && !i_wdata[0] |=>
        o_rx_fifo_reset == 4'h0 && o_tx_fifo_reset == 4'h0) else $error("fifo reset without enable");
    a_fifo_reset_pulse: assert property (wr && i_addr == 3'h2 && i_wdata[2:0] == 3'h7 |=>
        o_rx_fifo_reset == (4'h1 << ch_q) && o_tx_fifo_reset == (4'h1 << ch_q)) else $error("fifo reset missing");
    a_loop_mark: assert property ($past(o_loopback[0]) && $past(i_clk_en) |-> o_tx_pin[0] &&
        o_rx_shift_in[0] == $past(i_tx_shift_out[0])) else $error("loopback routing wrong");
    a_rdata_hold: assert property (!$past(rd) |-> $stable(o_rdata)) else $error("read data moved");
endmodule
bind uart_channel_register_decode uart_decode_chk chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_clk_en(i_clk_en), .i_chan_sel(i_chan_sel), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rx_data(i_rx_data), .i_line_status(i_line_status),
    .i_irq_code(i_irq_code), .i_tx_shift_out(i_tx_shift_out), .o_rx_shift_in(o_rx_shift_in),
    .o_tx_pin(o_tx_pin), .o_loopback(o_loopback), .o_line_control(o_line_control),
    .o_irq_enable(o_irq_enable), .o_fifo_control(o_fifo_control), .o_tx_data(o_tx_data),
    .o_tx_load(o_tx_load), .o_rx_read(o_rx_read), .o_irq_status_read(o_irq_status_read),
    .o_line_status_read(o_line_status_read), .o_modem_status_read(o_modem_status_read),
    .o_rx_fifo_reset(o_rx_fifo_reset), .o_tx_fifo_reset(o_tx_fifo_reset));
`default_nettype wire

// ### testbench/host_model.sv
// host processor model driving the parallel register bus
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    output logic [1:0] o_chan_sel,
    output logic [2:0] o_addr,
    output logic o_rd,
    output logic o_wr,
    output logic [7:0] o_wdata
);
    initial begin
        o_chan_sel = 2'h0;
        o_addr = 3'h0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 8'h00;
    end
    // one-cycle strobe; read data lands on the edge that takes the strobe and is sampled 1 ns later
    task automatic access(input logic w, input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge i_ref_clk);
        #1;
        o_chan_sel = ch;
        o_addr = a;
        o_wdata = d;
        o_rd = ~w;
        o_wr = w;
        @(posedge i_ref_clk);
        #1;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = ~d;
        q = i_rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the uart channel register decode
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst, clk_en, rd_s, wr_s;
    logic [1:0] chan_sel;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, tx_data, q;
    logic [31:0] rx_data, line_status, irq_enable, fifo_control;
    logic [15:0] irq_code;
    logic [63:0] divisor;
    logic [3:0] cts_n, dsr_n, ri_n, cd_n, rx_pin, tx_shift, tx_pin, rts_n, dtr_n, loopback;
    logic [3:0] irq_out, spare_n;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    host_model host (.i_ref_clk(clk), .i_rdata(rdata), .o_chan_sel(chan_sel), .o_addr(addr), .o_rd(rd_s),
        .o_wr(wr_s), .o_wdata(wdata));
    uart_channel_register_decode uut (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(clk_en), .i_chan_sel(chan_sel),
        .i_addr(addr), .i_rd(rd_s), .i_wr(wr_s), .i_wdata(wdata), .o_rdata(rdata), .i_rx_data(rx_data),
        .i_line_status(line_status), .i_irq_code(irq_code), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ri_n(ri_n),
        .i_cd_n(cd_n), .i_rx_pin(rx_pin), .i_tx_shift_out(tx_shift), .o_rx_shift_in(), .o_tx_pin(tx_pin),
        .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_irq_output_enable(irq_out), .o_spare_output_bit(spare_n),
        .o_loopback(loopback),
        .o_line_control(), .o_irq_enable(irq_enable), .o_fifo_control(fifo_control), .o_divisor(divisor),
        .o_tx_data(tx_data), .o_tx_load(), .o_rx_read(), .o_irq_status_read(), .o_line_status_read(),
        .o_modem_status_read(), .o_rx_fifo_reset(), .o_tx_fifo_reset());
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        host.access(1'b1, ch, a, d, dummy);
    endtask
    task automatic rd(input logic [1:0] ch, input logic [2:0] a);
        host.access(1'b0, ch, a, 8'h00, q);
    endtask
    task automatic t_scratch();
        rd(2'h0, 3'h7);
        check("scratch reset", q, 8'hFF);
        wr(2'h2, 3'h7, 8'h5A);
        rd(2'h2, 3'h7);
        check("scratch ch2", q, 8'h5A);
        rd(2'h1, 3'h7);
        check("scratch ch1", q, 8'hFF);
        clk_en = 1'b0;
        wr(2'h2, 3'h7, 8'h00);
        clk_en = 1'b1;
        rd(2'h2, 3'h7);
        check("scratch frozen", q, 8'h5A);
    endtask
    task automatic t_data_divisor();
        rx_data = 32'h3C2B1A09;
        wr(2'h1, 3'h3, 8'h03);
        wr(2'h1, 3'h0, 8'h41);
        check("tx data", tx_data, 8'h41);
        rd(2'h1, 3'h0);
        check("rx byte", q, 8'h1A);
        wr(2'h1, 3'h3, 8'h83);
        wr(2'h1, 3'h0, 8'h60);
        wr(2'h1, 3'h1, 8'h12);
        check("divisor", divisor[31:16], 16'h1260);
        rd(2'h1, 3'h1);
        check("divisor high", q, 8'h12);
        check("tx kept", tx_data, 8'h41);
        wr(2'h1, 3'h3, 8'hBF);
        wr(2'h1, 3'h1, 8'hFF);
        check("irq enable", irq_enable[15:8], 8'h0F);
        check("divisor hidden", divisor[31:16], 16'h1260);
        rd(2'h1, 3'h3);
        check("line control", q, 8'hBF);
        wr(2'h1, 3'h3, 8'h03);
        rd(2'h1, 3'h1);
        check("irq enable read", q, 8'h0F);
    endtask
    task automatic t_fifo();
        irq_code = 16'h0006;
        wr(2'h0, 3'h2, 8'hC7);
        check("fifo control", fifo_control[7:0], 8'hC1);
        rd(2'h0, 3'h2);
        check("irq status", q, 8'hC6);
        check("fifo after read", fifo_control[7:0], 8'hC1);
        wr(2'h0, 3'h2, 8'hC8);
        check("fifo no enable", fifo_control[7:0], 8'hC0);
        rd(2'h0, 3'h2);
        check("irq status off", q, 8'h06);
    endtask
    task automatic t_status();
        line_status = 32'hA5000000;
        rd(2'h3, 3'h5);
        check("line status", q, 8'hA5);
        wr(2'h3, 3'h5, 8'h00);
        wr(2'h3, 3'h6, 8'h00);
        rd(2'h3, 3'h5);
        check("line status kept", q, 8'hA5);
        cts_n = 4'h7;
        cd_n = 4'h7;
        repeat (4) @(posedge clk);
        rd(2'h3, 3'h6);
        check("modem status", q, 8'h99);
        rd(2'h3, 3'h6);
        check("modem deltas cleared", q, 8'h90);
    endtask
    task automatic t_modem();
        wr(2'h0, 3'h4, 8'hFF);
        rd(2'h0, 3'h4);
        check("modem control", q, 8'h1F);
        check("loopback", loopback[0], 1'b1);
        check("loop tx mark", tx_pin[0], 1'b1);
        check("loop rts off", rts_n[0], 1'b1);
        check("loop irq out off", irq_out[0], 1'b0);
        check("loop spare off", spare_n[0], 1'b1);
        wr(2'h0, 3'h4, 8'h0F);
        @(posedge clk);
        #1;
        check("rts on", rts_n[0], 1'b0);
        check("dtr on", dtr_n[0], 1'b0);
        check("irq out on", irq_out[0], 1'b1);
        check("spare on", spare_n[0], 1'b0);
        check("tx follows shift", tx_pin[0], 1'b0);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ceiling well above the fewer than a hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        rx_data = 32'h0;
        line_status = 32'h0;
        irq_code = 16'h0;
        cts_n = 4'hF;
        dsr_n = 4'hF;
        ri_n = 4'hF;
        cd_n = 4'hF;
        rx_pin = 4'hF;
        tx_shift = 4'h0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_scratch();
        t_data_divisor();
        t_fifo();
        t_status();
        t_modem();
        results();
    end
endmodule
`default_nettype wire
